// *** hw/low_power_mode_sequencer.v ***
// Power-mode and supply supervision sequencer: reset hold, supply monitor,
// regulator mode and Sleep/Stop/Standby sequencing with wake-up handling.
// Assumes analog comparators present supply_ok and the monitor compare as
// asynchronous levels; the processor asserts lp_enter_req for one cycle.
//
// Overview of operation
// R1 - Hold device in reset while supply is below power-on/down threshold.
// R2 - Monitor compares supply, interrupts on falling, rising or either crossing.
// R3 - Supply monitor stays inactive until software enables it.
// R4 - Regulator modes: main in Run, low power in Stop, off in Standby.
// R5 - Regulator on after reset; disabled, output floating, only in Standby.
// R6 - Sleep stops processor clock only; any interrupt or event wakes.
// R7 - Stop gates core clocks, PLL and fast oscillators; retains contents.
// R8 - In Stop, regulator runs main or low power as software chose.
// R9 - Stop exits on enabled event line: 16 pins, monitor, alarm, bus.
// R10 - Standby powers off regulator, core, PLL and fast oscillators.
// R11 - Standby exits on reset pin, dog reset, wake rising edge, alarm.
// R12 - Real-time clock, dog timer and their sources keep running always.
// R13 - Leaving Standby restarts through the normal reset sequence.
// R14 - Processor sets mode and regulator choice before the entry request.
`timescale 1ns/10ps
`include "lpm_defs.vh"
module low_power_mode_sequencer #(
    parameter LINES = 16,
    parameter HOLD_CYC = `RESET_HOLD_CYC
) (
    input wire clk,
    input wire reset,
    input wire supply_ok,
    input wire monitor_above,
    input wire monitor_enable,
    input wire [1:0] monitor_edge_sel,
    input wire [1:0] lp_mode_sel,
    input wire stop_low_power_sel,
    input wire lp_enter_req,
    input wire core_irq,
    input wire core_event,
    input wire [LINES-1:0] external_event_lines,
    input wire [LINES+2:0] stop_wake_enable,
    input wire rtc_alarm,
    input wire bus_wakeup,
    input wire wake_pin,
    input wire external_reset_pin_n,
    input wire independent_dog_reset,
    output reg system_reset,
    output reg monitor_irq,
    output reg monitor_out,
    output reg [1:0] regulator_mode,
    output reg regulator_enable,
    output reg regulator_out_en,
    output reg cpu_clk_en,
    output reg core_clk_en,
    output reg pll_en,
    output reg internal_fast_osc_en,
    output reg external_fast_osc_en,
    output reg core_power_on,
    output reg always_on_clk_en,
    output reg [2:0] lp_state
);
    // ******************************************************************
    // Input synchronisation
    // ******************************************************************
    localparam NPIN = LINES + 7;
    wire [NPIN-1:0] pins_raw;
    wire [NPIN-1:0] pins_s;
    assign pins_raw = {supply_ok, monitor_above, rtc_alarm, bus_wakeup,
                       wake_pin, external_reset_pin_n, independent_dog_reset,
                       external_event_lines};
    // Reset pin idles high so it must not look asserted out of reset
    // Supply levels start low so power-up is treated as a brown-out
    pin_sync #(
        .WIDTH(NPIN),
        .INIT({7'h02, {LINES{1'b0}}})
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .pin_in(pins_raw),
        .pin_out(pins_s)
    );
    wire supply_ok_s = pins_s[LINES+6];
    wire above_s = pins_s[LINES+5];
    wire alarm_s = pins_s[LINES+4];
    wire bus_wake_s = pins_s[LINES+3];
    wire wake_s = pins_s[LINES+2];
    wire ext_rst_n_s = pins_s[LINES+1];
    wire dog_rst_s = pins_s[LINES];
    wire [LINES-1:0] lines_s = pins_s[LINES-1:0];

    // ******************************************************************
    // Supply threshold monitor
    // ******************************************************************
    reg above_q;
    reg mon_armed_q;
    wire mon_active = monitor_enable & ~system_reset; // [R3]
    wire fell = mon_armed_q & above_q & ~above_s;
    wire rose = mon_armed_q & ~above_q & above_s;
    wire mon_irq_d = mon_active &
        ((fell & monitor_edge_sel[0]) | (rose & monitor_edge_sel[1])); // [R2]
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            above_q <= 1'b0;
            mon_armed_q <= 1'b0;
            monitor_irq <= 1'b0;
            monitor_out <= 1'b0;
        end else begin
            above_q <= above_s;
            // Arming one cycle late avoids a false edge on enable
            mon_armed_q <= mon_active; // [R3]
            monitor_irq <= mon_irq_d; // [R2]
            monitor_out <= mon_active & ~above_s; // [R2]
        end
    end

    // ******************************************************************
    // Wake sources
    // ******************************************************************
    reg wake_q;
    wire wake_rise = wake_s & ~wake_q;
    wire [LINES+2:0] stop_src = {bus_wake_s, alarm_s, monitor_out, lines_s};
    wire [LINES+2:0] stop_hits = stop_src & stop_wake_enable;
    wire stop_wake = |stop_hits; // [R9]
    // Any one of four sources ends Standby; the reset pin is active low
    wire wake_by_pin_rst = ~ext_rst_n_s;
    wire wake_by_dog = dog_rst_s;
    wire wake_by_edge = wake_rise;
    wire wake_by_alarm = alarm_s;
    wire standby_wake = wake_by_pin_rst | wake_by_dog | wake_by_edge |
                        wake_by_alarm; // [R11]
    // Core requests share the clock, so they bypass the synchroniser
    wire sleep_wake = core_irq | core_event; // [R6]
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_s;
        end
    end

    // ******************************************************************
    // State codes
    // ******************************************************************
    // Binary codes, shared with the lp_state output
    localparam [2:0] S_RESET = `ST_RESET;
    localparam [2:0] S_RUN = `ST_RUN;
    localparam [2:0] S_SLEEP = `ST_SLEEP;
    localparam [2:0] S_STOP = `ST_STOP;
    localparam [2:0] S_STANDBY = `ST_STANDBY;

    // ******************************************************************
    // Mode sequencer
    // ******************************************************************
    localparam CW = 16;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [CW-1:0] hold_q;
    reg stop_lp_q;
    // Counter stops at the limit, so a long hold cannot wrap round
    wire [CW-1:0] hold_lim = HOLD_CYC[CW-1:0];
    wire hold_done = (hold_q >= hold_lim);
    wire brown = ~supply_ok_s;
    // Reset pin and dog reset also restart from Run modes
    wire sys_rst_src = brown | ~ext_rst_n_s | dog_rst_s;
    // Entry is taken only from Run; elsewhere a request is dropped
    wire enter_ok = lp_enter_req && (state_q == S_RUN); // [R14]
    // Choice applies on the entry edge itself, not one cycle later
    wire stop_lp_d = enter_ok ? stop_low_power_sel : stop_lp_q; // [R8]

    always @* begin
        state_d = state_q;
        case (state_q)
            S_RESET: begin
                if (hold_done && !sys_rst_src) begin
                    state_d = S_RUN;
                end
            end
            S_RUN: begin
                if (enter_ok) begin // [R14]
                    case (lp_mode_sel)
                        `MODE_SLEEP: state_d = S_SLEEP;
                        `MODE_STOP: state_d = S_STOP;
                        `MODE_STANDBY: state_d = S_STANDBY;
                        default: state_d = S_RUN;
                    endcase
                end
            end
            S_SLEEP: begin
                if (sleep_wake) begin
                    state_d = S_RUN; // [R6]
                end
            end
            S_STOP: begin
                if (stop_wake) begin
                    state_d = S_RUN; // [R9]
                end
            end
            S_STANDBY: begin
                if (standby_wake) begin
                    state_d = S_RESET; // [R11] [R13]
                end
            end
            default: state_d = S_RESET;
        endcase
        // Brown-out and reset sources override, except Standby keeps
        // waiting for its own wake set
        if (sys_rst_src && state_q != S_STANDBY) begin
            state_d = S_RESET; // [R1]
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= S_RESET;
            hold_q <= {CW{1'b0}};
            stop_lp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // Hold counter restarts whenever a reset source is present
            if (state_q != `ST_RESET || sys_rst_src) begin
                hold_q <= {CW{1'b0}}; // [R1]
            end else if (!hold_done) begin
                hold_q <= hold_q + {{(CW-1){1'b0}}, 1'b1};
            end
            // Regulator choice kept from the last accepted request
            stop_lp_q <= stop_lp_d; // [R8] [R14]
        end
    end

    // ******************************************************************
    // Registered outputs
    // ******************************************************************
    // Standby counts as reset: the core domain is unpowered there
    wire hold_reset_d = (state_d == S_RESET) ||
                        (state_d == S_STANDBY); // [R1] [R13]
    // Outputs follow the next state, so they move with lp_state
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            system_reset <= 1'b1;
            regulator_mode <= `REG_MAIN;
            regulator_enable <= 1'b1;
            regulator_out_en <= 1'b1;
            cpu_clk_en <= 1'b0;
            core_clk_en <= 1'b0;
            pll_en <= 1'b0;
            internal_fast_osc_en <= 1'b1;
            external_fast_osc_en <= 1'b0;
            core_power_on <= 1'b1;
            always_on_clk_en <= 1'b1;
            lp_state <= `ST_RESET;
        end else begin
            lp_state <= state_d;
            system_reset <= hold_reset_d; // [R1] [R13]
            always_on_clk_en <= 1'b1; // [R12]
            case (state_d)
                S_RUN, S_SLEEP: begin
                    regulator_mode <= `REG_MAIN; // [R4]
                    regulator_enable <= 1'b1;
                    regulator_out_en <= 1'b1;
                    cpu_clk_en <= (state_d == S_RUN); // [R6]
                    core_clk_en <= 1'b1;
                    pll_en <= 1'b1;
                    internal_fast_osc_en <= 1'b1;
                    external_fast_osc_en <= 1'b1;
                    core_power_on <= 1'b1;
                end
                S_STOP: begin
                    regulator_mode <= stop_lp_d ? `REG_LOW_POWER
                                                : `REG_MAIN; // [R4] [R8]
                    regulator_enable <= 1'b1;
                    regulator_out_en <= 1'b1;
                    cpu_clk_en <= 1'b0; // [R7]
                    core_clk_en <= 1'b0;
                    pll_en <= 1'b0;
                    internal_fast_osc_en <= 1'b0;
                    external_fast_osc_en <= 1'b0;
                    core_power_on <= 1'b1; // Contents retained
                end
                S_STANDBY: begin
                    regulator_mode <= `REG_POWER_DOWN; // [R4] [R10]
                    regulator_enable <= 1'b0; // [R5]
                    regulator_out_en <= 1'b0;
                    cpu_clk_en <= 1'b0;
                    core_clk_en <= 1'b0;
                    pll_en <= 1'b0;
                    internal_fast_osc_en <= 1'b0;
                    external_fast_osc_en <= 1'b0;
                    core_power_on <= 1'b0;
                end
                default: begin
                    // Reset: regulator on, core powered, clocks held
                    regulator_mode <= `REG_MAIN; // [R5]
                    regulator_enable <= 1'b1;
                    regulator_out_en <= 1'b1;
                    cpu_clk_en <= 1'b0;
                    core_clk_en <= 1'b0;
                    pll_en <= 1'b0;
                    internal_fast_osc_en <= 1'b1;
                    external_fast_osc_en <= 1'b0;
                    core_power_on <= 1'b1; // [R13]
                end
            endcase
        end
    end
endmodule // low_power_mode_sequencer

// *** hw/lpm_defs.vh ***
// Constants for the low-power mode sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef LPM_DEFS_VH
`define LPM_DEFS_VH

// Mode select codes on lp_mode_sel
`define MODE_SLEEP 2'h0
`define MODE_STOP 2'h1
`define MODE_STANDBY 2'h2

// Regulator mode codes on regulator_mode
`define REG_MAIN 2'h0
`define REG_LOW_POWER 2'h1
`define REG_POWER_DOWN 2'h2

// Sequencer state codes
`define ST_RESET 3'h0
`define ST_RUN 3'h1
`define ST_SLEEP 3'h2
`define ST_STOP 3'h3
`define ST_STANDBY 3'h4

// Supply monitor interrupt edge selects
`define EDGE_FALL 2'h1
`define EDGE_RISE 2'h2

// Minimum reset stretch after supply good, in ns, and in cycles
`define RESET_HOLD_NS 1000
`define CLK_PERIOD_NS 100
`define RESET_HOLD_CYC ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hw/pin_sync.v ***
// Three-stage pin synchroniser with agreement filter, one per bit.
// Assumes inputs asynchronous to clk; output changes once stages 2, 3 agree.
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire reset,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg o_q;
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    s1_q <= INIT[i];
                    s2_q <= INIT[i];
                    s3_q <= INIT[i];
                    o_q <= INIT[i];
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // Only stages 2 and 3 are looked at; stage 1 may be metastable
                    if (s2_q == s3_q) begin
                        o_q <= s3_q;
                    end
                end
            end
            assign pin_out[i] = o_q;
        end
    endgenerate
endmodule // pin_sync

// *** tb/core_model.sv ***
// Processor core model that issues low-power entry requests.
// Assumes the sequencer samples the request on the rising clock edge.
`timescale 1ns/10ps
module core_model (
    input wire clk,
    output reg [1:0] lp_mode_sel,
    output reg stop_low_power_sel,
    output reg lp_enter_req
);
    initial begin
        lp_mode_sel = 2'h3;
        stop_low_power_sel = 1'b0;
        lp_enter_req = 1'b0;
    end
    // Mode and regulator choice settle a cycle ahead of the pulse
    task request(input [1:0] mode, input lp);
        begin
            @(negedge clk);
            lp_mode_sel = mode;
            stop_low_power_sel = lp;
            @(negedge clk);
            lp_enter_req = 1'b1;
            @(negedge clk);
            lp_enter_req = 1'b0;
        end
    endtask
endmodule // core_model

// *** tb/low_power_mode_sequencer_tb.sv ***
// Self-checking bench for the low-power mode sequencer.
// Assumes core_model issues requests and the checker is bound.
`timescale 1ns/10ps
`include "lpm_defs.vh"
module low_power_mode_sequencer_tb;
    reg clk, reset, supply_ok, monitor_above, monitor_enable;
    reg core_irq, core_event;
    reg [1:0] monitor_edge_sel;
    reg [15:0] external_event_lines;
    reg [18:0] stop_wake_enable;
    reg [3:0] wk;
    wire [1:0] lp_mode_sel, regulator_mode;
    wire stop_low_power_sel, lp_enter_req, system_reset, monitor_irq;
    wire monitor_out, regulator_enable, cpu_clk_en, core_clk_en, pll_en;
    wire internal_fast_osc_en, external_fast_osc_en, core_power_on;
    wire [2:0] lp_state;
    wire [7:0] outs = {system_reset, regulator_enable, cpu_clk_en,
        core_clk_en, pll_en, internal_fast_osc_en, external_fast_osc_en,
        core_power_on};
    integer mismatches = 0, n_tests = 0, cycles = 0, i;

    // Short reset stretch keeps the run brief
    low_power_mode_sequencer #(.LINES(16), .HOLD_CYC(2))
    u_low_power_mode_sequencer (.clk(clk), .reset(reset),
        .supply_ok(supply_ok), .monitor_above(monitor_above),
        .monitor_enable(monitor_enable), .monitor_edge_sel(monitor_edge_sel),
        .lp_mode_sel(lp_mode_sel), .stop_low_power_sel(stop_low_power_sel),
        .lp_enter_req(lp_enter_req), .core_irq(core_irq),
        .core_event(core_event), .external_event_lines(external_event_lines),
        .stop_wake_enable(stop_wake_enable), .rtc_alarm(wk[1]),
        .bus_wakeup(1'b0), .wake_pin(wk[0]),
        .external_reset_pin_n(~wk[3]), .independent_dog_reset(wk[2]),
        .system_reset(system_reset), .monitor_irq(monitor_irq),
        .monitor_out(monitor_out), .regulator_mode(regulator_mode),
        .regulator_enable(regulator_enable), .regulator_out_en(),
        .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en), .pll_en(pll_en),
        .internal_fast_osc_en(internal_fast_osc_en),
        .external_fast_osc_en(external_fast_osc_en),
        .core_power_on(core_power_on), .always_on_clk_en(), .lp_state(lp_state));
    core_model u_core_model (.clk(clk), .lp_mode_sel(lp_mode_sel),
        .stop_low_power_sel(stop_low_power_sel), .lp_enter_req(lp_enter_req));

    task check(input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wait_in(input [2:0] want);
        integer k;
        begin
            for (k = 0; k < 60 && lp_state !== want; k = k + 1) @(negedge clk);
            check({5'h00, lp_state}, {5'h00, want});
        end
    endtask
    task count_irq(input [7:0] exp, input eo);
        reg [7:0] n;
        begin
            n = 8'h00;
            repeat (12) begin
                @(negedge clk);
                if (monitor_irq === 1'b1) n = n + 8'h01;
            end
            check(n, exp);
            check({7'h00, monitor_out}, {7'h00, eo});
        end
    endtask
    task t_reset;
        begin
            repeat (2) @(negedge clk);
            check(outs, 8'hC5);
            reset = 1'b0;
            wait_in(`ST_RUN);
            check(outs, 8'h7F);
            check({6'h00, regulator_mode}, {6'h00, `REG_MAIN});
        end
    endtask
    task t_sleep;
        begin
            for (i = 1; i < 3; i = i + 1) begin
                u_core_model.request(`MODE_SLEEP, 1'b0);
                check(outs, 8'h5F);
                repeat (3) @(negedge clk);
                {core_event, core_irq} = i[1:0];
                @(negedge clk);
                {core_event, core_irq} = 2'h0;
                check({5'h00, lp_state}, {5'h00, `ST_RUN});
            end
            u_core_model.request(2'h3, 1'b0);
            check({5'h00, lp_state}, {5'h00, `ST_RUN});
        end
    endtask
    task t_stop;
        begin
            stop_wake_enable = 19'h00020;
            for (i = 0; i < 2; i = i + 1) begin
                u_core_model.request(`MODE_STOP, i[0]);
                check(outs, 8'h41);
                check({6'h00, regulator_mode}, i ? 8'h01 : 8'h00);
                external_event_lines = 16'h0040;
                repeat (8) @(negedge clk);
                check({5'h00, lp_state}, {5'h00, `ST_STOP});
                external_event_lines = 16'h0020;
                wait_in(`ST_RUN);
                external_event_lines = 16'h0000;
                // Line must drain through the synchroniser before re-entry
                repeat (5) @(negedge clk);
            end
        end
    endtask
    task t_standby;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                u_core_model.request(`MODE_STANDBY, 1'b0);
                check(outs, 8'h80);
                check({6'h00, regulator_mode}, {6'h00, `REG_POWER_DOWN});
                wk = 4'h1 << i;
                wait_in(`ST_RESET);
                check(outs, 8'hC5);
                wk = 4'h0;
                wait_in(`ST_RUN);
            end
        end
    endtask
    task t_monitor;
        begin
            monitor_edge_sel = 2'h3;
            monitor_above = 1'b0;
            count_irq(8'h00, 1'b0);
            monitor_above = 1'b1;
            count_irq(8'h00, 1'b0);
            monitor_enable = 1'b1;
            for (i = 1; i < 4; i = i + 1) begin
                monitor_edge_sel = i[1:0];
                repeat (2) @(negedge clk);
                monitor_above = 1'b0;
                count_irq({7'h00, monitor_edge_sel[0]}, 1'b1);
                monitor_above = 1'b1;
                count_irq({7'h00, monitor_edge_sel[1]}, 1'b0);
            end
        end
    endtask
    task t_brownout;
        begin
            supply_ok = 1'b0;
            wait_in(`ST_RESET);
            repeat (5) @(negedge clk);
            check(outs, 8'hC5);
            supply_ok = 1'b1;
            wait_in(`ST_RUN);
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d, mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Bounds a hang well beyond the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            print_verdict;
        end
    end
    initial begin
        {reset, supply_ok, monitor_above} = 3'h7;
        {monitor_enable, core_irq, core_event} = 3'h0;
        monitor_edge_sel = 2'h0;
        external_event_lines = 16'h0000;
        stop_wake_enable = 19'h00000;
        wk = 4'h0;
        t_reset;
        t_sleep;
        t_stop;
        t_standby;
        t_monitor;
        t_brownout;
        print_verdict;
    end
endmodule // low_power_mode_sequencer_tb

// *** tb/lpm_seq_sva.sv ***
// Checker for the low-power mode sequencer, bound to its top ports.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/10ps
`include "lpm_defs.vh"
module lpm_seq_sva #(
    parameter LINES = 16,
    parameter HOLD_CYC = `RESET_HOLD_CYC
) (
    input wire clk,
    input wire reset,
    input wire supply_ok,
    input wire monitor_enable,
    input wire [1:0] lp_mode_sel,
    input wire stop_low_power_sel,
    input wire lp_enter_req,
    input wire [LINES-1:0] external_event_lines,
    input wire [LINES+2:0] stop_wake_enable,
    input wire wake_pin,
    input wire system_reset,
    input wire monitor_irq,
    input wire monitor_out,
    input wire [1:0] regulator_mode,
    input wire regulator_enable,
    input wire regulator_out_en,
    input wire core_clk_en,
    input wire pll_en,
    input wire core_power_on,
    input wire always_on_clk_en,
    input wire [2:0] lp_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire run = lp_state == `ST_RUN;
    wire stop = lp_state == `ST_STOP;
    wire stby = lp_state == `ST_STANDBY;

    reset_hold_a: assert property (!supply_ok [*6] |-> system_reset)
        else $error("reset not held on low supply");
    reset_stretch_a: assert property ($fell(system_reset) |->
        $past(supply_ok, HOLD_CYC)) else $error("reset left too early");
    reg_float_a: assert property ((regulator_enable && regulator_out_en)
        == !stby) else $error("regulator enable wrong for state");
    power_down_a: assert property (stby |->
        regulator_mode == `REG_POWER_DOWN && !core_power_on && system_reset)
        else $error("standby not powered down");
    stop_entry_a: assert property (lp_enter_req && run &&
        lp_mode_sel == `MODE_STOP |=> stop && regulator_mode ==
        ($past(stop_low_power_sel) ? `REG_LOW_POWER : `REG_MAIN))
        else $error("stop entry or regulator choice wrong");
    stop_gate_a: assert property (stop |->
        !core_clk_en && !pll_en && core_power_on)
        else $error("stop clocks or power wrong");
    stop_wake_a: assert property (stop && |(external_event_lines &
        stop_wake_enable[LINES-1:0]) |-> ##[1:6] run)
        else $error("enabled line did not wake stop");
    standby_exit_a: assert property (stby && $rose(wake_pin) |->
        ##[1:8] lp_state == `ST_RESET) else $error("wake edge ignored");
    refuse_a: assert property (lp_enter_req && run &&
        lp_mode_sel == 2'h3 |=> run) else $error("reserved mode taken");
    monitor_idle_a: assert property (!monitor_enable [*3] |->
        !monitor_irq && !monitor_out) else $error("monitor active unenabled");
    always_on_a: assert property (always_on_clk_en)
        else $error("always-on clock dropped");

    cover property (stop ##1 run);
    cover property (stby ##[1:8] lp_state == `ST_RESET);
    cover property (monitor_irq);
endmodule // lpm_seq_sva

bind low_power_mode_sequencer lpm_seq_sva #(.LINES(LINES),
    .HOLD_CYC(HOLD_CYC)) u_lpm_seq_sva (.clk(clk), .reset(reset),
    .supply_ok(supply_ok), .monitor_enable(monitor_enable),
    .lp_mode_sel(lp_mode_sel), .stop_low_power_sel(stop_low_power_sel),
    .lp_enter_req(lp_enter_req), .external_event_lines(external_event_lines),
    .stop_wake_enable(stop_wake_enable), .wake_pin(wake_pin),
    .system_reset(system_reset), .monitor_irq(monitor_irq),
    .monitor_out(monitor_out), .regulator_mode(regulator_mode),
    .regulator_enable(regulator_enable), .regulator_out_en(regulator_out_en),
    .core_clk_en(core_clk_en), .pll_en(pll_en), .core_power_on(core_power_on),
    .always_on_clk_en(always_on_clk_en), .lp_state(lp_state));
